// ==== hdl/fsit_issue_timing.sv ====
// Issue-timing and occupancy control for the FP/SIMD/IMUL cluster.
// Sits beside the in-order issue stage; one clock, no software registers.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - FP adds: latency five, issue every cycle
// - Packed double add: latency six, gap five
// - Scalar double/packed single mul: five, gap two
// - Packed double mul blocks multiplier nine cycles
// - 32-bit integer multiply: five, every cycle
// - 16-bit integer multiply: six, every cycle
// - Divide/sqrt on slow radix-2 iterative divider
// - One divider shared; busy for both threads
// - Divider time depends on size and values
// - Consumers of FP results wait two more
// - Line-split 16-byte load adds fourteen cycles
// - Reissued memory access blocks short-latency issue
module fsit_issue_timing #(
  parameter int REGS = fsit_pkg::FSIT_REGS,
  parameter int SALU_UNITS = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire fsit_pkg::fsit_req_s req,
  input wire logic memReissue,
  output logic issueReady,
  output logic issueTaken,
  output logic divBusy,
  output logic [fsit_pkg::FSIT_CW-1:0] lastLatency
);
  import fsit_pkg::*;

  // Longest divide time that still leaves room for the late writeback delay
  localparam int DIV_CAP = (1 << FSIT_CW) - 1 - int'(FP_WB_EXTRA);

  // Elaboration checks: the scoreboard covers every register index, and the
  // counters must hold the nine-cycle packed double multiply as well as a divide
  if (REGS != (1 << FSIT_RW)) begin : g_bad_regs
    $error("REGS must match register index width");
  end
  if (SALU_UNITS < 1 || SALU_UNITS > 2) begin : g_bad_salu
    $error("SALU_UNITS must be 1 or 2");
  end
  if (DIV_CAP < int'(LAT_9)) begin : g_bad_cap
    $error("Counter width too small for the divider");
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic fsit_unit_e unitOf(input fsit_op_e op);
    case (op)
      FSIT_OP_SIMD_ALU: unitOf = FSIT_U_SALU;
      FSIT_OP_SIMD_SHIFT, FSIT_OP_SIMD_SHUF: unitOf = FSIT_U_SSHF;
      FSIT_OP_FADD, FSIT_OP_FADD_PD: unitOf = FSIT_U_ADD;
      FSIT_OP_DIV: unitOf = FSIT_U_DIV;
      FSIT_OP_LOAD, FSIT_OP_LOAD_SPLIT: unitOf = FSIT_U_MEM;
      FSIT_OP_NONE, FSIT_OP_INT: unitOf = FSIT_U_NONE;
      default: unitOf = FSIT_U_MUL;
    endcase
  endfunction

  // Countdown shared by every occupancy and scoreboard counter; stops at zero
  function automatic logic [FSIT_CW-1:0] tick(input logic [FSIT_CW-1:0] v);
    tick = (v != '0) ? v - LAT_1 : '0;
  endfunction

  function automatic fsit_time_s timeOf(input fsit_op_e op, input logic [1:0] sz,
                                        input logic [3:0] sig);
    logic [FSIT_DIV_W-1:0] d;
    logic [FSIT_CW-1:0] divT;
    d = FSIT_DIV_W'(DIV_BASE) + FSIT_DIV_W'(DIV_STEP) * FSIT_DIV_W'({sz, 1'b1})
        + FSIT_DIV_W'(sig);
    // Largest size class with divSig of 2 or more saturates instead of wrapping the counters
    divT = (d > FSIT_DIV_W'(DIV_CAP)) ? FSIT_CW'(DIV_CAP) : d[FSIT_CW-1:0];
    timeOf = '{lat: LAT_1, gap: LAT_1, fpRes: 1'b0};
    case (op)
      FSIT_OP_SIMD_MUL128: timeOf = '{lat: LAT_5, gap: LAT_2, fpRes: 1'b0};
      FSIT_OP_SIMD_MUL64: timeOf = '{lat: LAT_4, gap: LAT_1, fpRes: 1'b0};
      FSIT_OP_FADD: timeOf = '{lat: LAT_5, gap: LAT_1, fpRes: 1'b1};
      FSIT_OP_FADD_PD: timeOf = '{lat: LAT_6, gap: LAT_5, fpRes: 1'b1};
      FSIT_OP_FMUL_X87: timeOf = '{lat: LAT_5, gap: LAT_2, fpRes: 1'b1};
      FSIT_OP_FMUL_SS: timeOf = '{lat: LAT_4, gap: LAT_1, fpRes: 1'b1};
      FSIT_OP_FMUL_SD_PS: timeOf = '{lat: LAT_5, gap: LAT_2, fpRes: 1'b1};
      FSIT_OP_FMUL_PD: timeOf = '{lat: LAT_9, gap: LAT_9, fpRes: 1'b1};
      FSIT_OP_IMUL32: timeOf = '{lat: LAT_5, gap: LAT_1, fpRes: 1'b0};
      FSIT_OP_IMUL16: timeOf = '{lat: LAT_6, gap: LAT_1, fpRes: 1'b0};
      FSIT_OP_DIV: timeOf = '{lat: divT, gap: divT, fpRes: 1'b1};
      FSIT_OP_LOAD: timeOf = '{lat: LOAD_LAT, gap: LAT_1, fpRes: 1'b0};
      FSIT_OP_LOAD_SPLIT: timeOf = '{lat: FSIT_CW'(LOAD_LAT + SPLIT_EXTRA),
                                     gap: FSIT_CW'(LOAD_LAT + SPLIT_EXTRA),
                                     fpRes: 1'b0};
      default: timeOf = '{lat: LAT_1, gap: LAT_1, fpRes: 1'b0};
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Per-register countdown until result usable; per-unit countdown until free
  logic [FSIT_CW-1:0] regWait [REGS];
  logic [FSIT_CW-1:0] addWait, mulWait, divWait, memWait;

  fsit_unit_e reqUnit;
  fsit_time_s reqTime;
  logic [FSIT_CW-1:0] resWait;
  logic [FSIT_CW-1:0] srcAWait;
  logic [FSIT_CW-1:0] srcBWait;
  logic depHold, unitHold, shortOp, reissueHold;

  // Decode of the op on offer
  always_comb begin
    reqUnit = unitOf(req.op);
    reqTime = timeOf(req.op, req.divSize, req.divSig);
    // FP results write back late, so the scoreboard adds the extra delay
    resWait = FSIT_CW'(reqTime.lat + (reqTime.fpRes ? FP_WB_EXTRA : '0));
    shortOp = (reqTime.lat == LAT_1);
  end

  // Both sources are looked up even for ops that read fewer; this can only
  // delay an op, never let one issue early
  always_comb begin
    srcAWait = regWait[req.srcA];
    srcBWait = regWait[req.srcB];
    depHold = (srcAWait > LAT_1) || (srcBWait > LAT_1);
  end

  // The divider must drain fully, the pipelined units only to their gap
  always_comb begin
    case (reqUnit)
      FSIT_U_ADD: unitHold = (addWait > LAT_1);
      FSIT_U_MUL: unitHold = (mulWait > LAT_1);
      FSIT_U_DIV: unitHold = (divWait != '0);
      FSIT_U_MEM: unitHold = (memWait > LAT_1);
      default: unitHold = 1'b0;
    endcase
  end

  // A reissued access blocks only latency-one ops behind it
  always_comb begin
    reissueHold = memReissue && shortOp;
    issueReady = !depHold && !unitHold && !reissueHold;
    issueTaken = req.valid && req.op != FSIT_OP_NONE && issueReady;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dependency scoreboard, one countdown per register
  for (genvar g = 0; g < REGS; g++) begin : g_score
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        regWait[g] <= '0;
      end else if (issueTaken && req.dst == FSIT_RW'(g)) begin
        regWait[g] <= resWait;
      end else begin
        regWait[g] <= tick(regWait[g]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Adder occupancy; a packed double add keeps it for its whole gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addWait <= '0;
    end else if (issueTaken && reqUnit == FSIT_U_ADD) begin
      addWait <= reqTime.gap;
    end else begin
      addWait <= tick(addWait);
    end
  end

  // Multiplier occupancy, shared by FP, SIMD and integer multiplies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mulWait <= '0;
    end else if (issueTaken && reqUnit == FSIT_U_MUL) begin
      mulWait <= reqTime.gap;
    end else begin
      mulWait <= tick(mulWait);
    end
  end

  // Load port occupancy; a line split holds it for the whole penalty
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memWait <= '0;
    end else if (issueTaken && reqUnit == FSIT_U_MEM) begin
      memWait <= reqTime.gap;
    end else begin
      memWait <= tick(memWait);
    end
  end

  // Divider is thread-agnostic: either thread sees it busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divWait <= '0;
    end else if (issueTaken && reqUnit == FSIT_U_DIV) begin
      divWait <= reqTime.gap;
    end else begin
      divWait <= tick(divWait);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latency of the last op taken, held until the next one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastLatency <= '0;
    end else if (issueTaken) begin
      lastLatency <= reqTime.lat;
    end
  end

  // Divider busy flag as both threads see it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divBusy <= 1'b0;
    end else begin
      divBusy <= (issueTaken && reqUnit == FSIT_U_DIV) || (divWait > LAT_1);
    end
  end

endmodule

`default_nettype wire

// ==== hdl/fsit_pkg.sv ====
// Package for the FP/SIMD issue-timing block: op classes, latencies, intervals.
// Assumes one core clock; the issue stage presents at most one op per cycle here.
package fsit_pkg;

  typedef enum logic [4:0] {
    FSIT_OP_NONE,
    FSIT_OP_SIMD_ALU,
    FSIT_OP_SIMD_SHIFT,
    FSIT_OP_SIMD_SHUF,
    FSIT_OP_SIMD_MUL128,
    FSIT_OP_SIMD_MUL64,
    FSIT_OP_FADD,
    FSIT_OP_FADD_PD,
    FSIT_OP_FMUL_X87,
    FSIT_OP_FMUL_SS,
    FSIT_OP_FMUL_SD_PS,
    FSIT_OP_FMUL_PD,
    FSIT_OP_IMUL32,
    FSIT_OP_IMUL16,
    FSIT_OP_DIV,
    FSIT_OP_LOAD,
    FSIT_OP_LOAD_SPLIT,
    FSIT_OP_INT
  } fsit_op_e;

  typedef enum logic [2:0] {
    FSIT_U_NONE, FSIT_U_SALU, FSIT_U_SSHF, FSIT_U_ADD, FSIT_U_MUL, FSIT_U_DIV, FSIT_U_MEM
  } fsit_unit_e;

  localparam int FSIT_CW = 6;
  localparam int FSIT_REGS = 16;
  localparam int FSIT_RW = 4;

  // Request from the issue stage
  typedef struct packed {
    logic valid;
    fsit_op_e op;
    logic thread;
    logic [FSIT_RW-1:0] dst;
    logic [FSIT_RW-1:0] srcA;
    logic [FSIT_RW-1:0] srcB;
    logic [1:0] divSize;
    logic [3:0] divSig;
  } fsit_req_s;

  typedef struct packed {
    logic [FSIT_CW-1:0] lat;
    logic [FSIT_CW-1:0] gap;
    logic fpRes;
  } fsit_time_s;

  localparam logic [FSIT_CW-1:0] LAT_1 = 6'h01;
  localparam logic [FSIT_CW-1:0] LAT_2 = 6'h02;
  localparam logic [FSIT_CW-1:0] LAT_4 = 6'h04;
  localparam logic [FSIT_CW-1:0] LAT_5 = 6'h05;
  localparam logic [FSIT_CW-1:0] LAT_6 = 6'h06;
  localparam logic [FSIT_CW-1:0] LAT_9 = 6'h09;
  localparam logic [FSIT_CW-1:0] FP_WB_EXTRA = 6'h02;
  localparam logic [FSIT_CW-1:0] SPLIT_EXTRA = 6'h0e;
  localparam logic [FSIT_CW-1:0] LOAD_LAT = 6'h01;
  // Radix-2 divider: base plus one step per bit of the size class
  localparam logic [FSIT_CW-1:0] DIV_BASE = 6'h04;
  localparam logic [FSIT_CW-1:0] DIV_STEP = 6'h08;
  localparam int FSIT_DIV_W = 8;

endpackage

// ==== tb/fsit_issue_timing_monitor.sv ====
// Checker of issue timing at the ports of the issue-timing block.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fsit_issue_timing_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire fsit_pkg::fsit_req_s req,
  input wire logic memReissue,
  input wire logic issueReady,
  input wire logic issueTaken,
  input wire logic divBusy,
  input wire logic [fsit_pkg::FSIT_CW-1:0] lastLatency
);
  import fsit_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_mulQuiet;
    !(issueTaken && req.op inside {FSIT_OP_FMUL_SD_PS, FSIT_OP_FMUL_PD});
  endsequence
  a_take_ready: assert property (issueTaken |-> issueReady && req.valid)
    else $error("issue without ready");
  a_add_lat: assert property (issueTaken && req.op == FSIT_OP_FADD |=> lastLatency == LAT_5)
    else $error("add latency wrong");
  a_addpd_gap: assert property (issueTaken && req.op == FSIT_OP_FADD_PD
    |=> !(issueTaken && req.op == FSIT_OP_FADD_PD) [*4]) else $error("packed add too soon");
  a_mul_gap: assert property (issueTaken && req.op == FSIT_OP_FMUL_SD_PS |=> s_mulQuiet)
    else $error("multiply too soon");
  a_mulpd_gap: assert property (issueTaken && req.op == FSIT_OP_FMUL_PD |=> s_mulQuiet [*8])
    else $error("multiply after packed double too soon");
  a_imul_lat: assert property (issueTaken && req.op == FSIT_OP_IMUL16 |=> lastLatency == LAT_6)
    else $error("short multiply latency wrong");
  a_div_busy: assert property (issueTaken && req.op == FSIT_OP_DIV |=> divBusy)
    else $error("divider not busy");
  a_div_hold: assert property (divBusy |-> !(issueTaken && req.op == FSIT_OP_DIV))
    else $error("divide issued while busy");
  a_reissue_hold: assert property (memReissue && req.op == FSIT_OP_INT |-> !issueReady)
    else $error("short op ready during reissue");
  a_split_lat: assert property (issueTaken && req.op == FSIT_OP_LOAD_SPLIT
    |=> lastLatency == LOAD_LAT + SPLIT_EXTRA) else $error("split load latency wrong");
endmodule
bind fsit_issue_timing fsit_issue_timing_monitor u_fsit_issue_timing_monitor (.clk(clk),
  .rst_n(rst_n), .req(req), .memReissue(memReissue), .issueReady(issueReady),
  .issueTaken(issueTaken), .divBusy(divBusy), .lastLatency(lastLatency));
`default_nettype wire

// ==== tb/fsit_issue_stage.sv ====
// In-order issue stage model: holds one request until it is taken.
// Assumes the bench posts a new request just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module fsit_issue_stage (
  input wire logic clk,
  input wire logic issueTaken,
  input wire fsit_pkg::fsit_req_s next,
  input wire logic [7:0] seq,
  output fsit_pkg::fsit_req_s req,
  output logic done
);
  import fsit_pkg::*;
  logic [7:0] seen = 8'h00;
  logic [7:0] doneSeq = 8'h00;
  initial req = '0;
  assign done = (doneSeq == seq);
  // Inputs move on the falling edge, away from sampling
  always @(negedge clk) begin
    if (seq != seen) begin
      req <= next;
      seen <= seq;
    end else if (done) begin
      req.valid <= 1'b0;
    end
  end
  always @(posedge clk) if (issueTaken) doneSeq <= seen;
endmodule
`default_nettype wire

// ==== tb/fsit_issue_timing_tb_top.sv ====
// Testbench: issues op pairs and measures the issue gap in cycles.
// Assumes the issue-stage model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module fsit_issue_timing_tb_top;
  import fsit_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic memReissue = 1'b0;
  logic issueReady, issueTaken, divBusy, done;
  logic [FSIT_CW-1:0] lastLatency;
  logic [7:0] seq = 8'h00;
  fsit_req_s req, nxt;
  int num_errors = 0;
  int tests_run = 0;
  always #12.5 clk = ~clk;
  fsit_issue_stage u_fsit_issue_stage (.clk(clk), .issueTaken(issueTaken), .next(nxt),
    .seq(seq), .req(req), .done(done));
  fsit_issue_timing u_fsit_issue_timing (.clk(clk), .rst_n(rst_n), .req(req),
    .memReissue(memReissue), .issueReady(issueReady), .issueTaken(issueTaken),
    .divBusy(divBusy), .lastLatency(lastLatency));
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Returns cycles from posting to issue; 1 means back to back
  task automatic go(input fsit_op_e op, input logic [3:0] d, input logic [3:0] s, output int c);
    nxt.op = op;
    nxt.dst = d;
    nxt.srcA = s;
    seq++;
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (!done && c < 300);
    if (!done) begin
      cmp(32'(done), 32'h1);
      test_done();
    end
  endtask
  task automatic pair(input fsit_op_e a, input fsit_op_e b, input logic [3:0] s,
      input logic [31:0] gap, input logic [31:0] lat);
    int c;
    nxt.thread = 1'b0;
    go(a, 4'h1, 4'h0, c);
    cmp(32'(lastLatency), lat);
    nxt.thread = 1'b1;
    go(b, 4'h3, s, c);
    cmp(c, gap);
    repeat (8'h5a) @(posedge clk);
    #1;
  endtask
  task automatic t_adder;
    pair(FSIT_OP_FADD, FSIT_OP_FADD, 4'h0, 6'h01, 6'h05);
    pair(FSIT_OP_FADD, FSIT_OP_INT, 4'h1, 6'h07, 6'h05);
    pair(FSIT_OP_FADD_PD, FSIT_OP_FADD_PD, 4'h0, 6'h05, 6'h06);
    pair(FSIT_OP_SIMD_ALU, FSIT_OP_SIMD_ALU, 4'h0, 6'h01, 6'h01);
  endtask
  task automatic t_mul;
    pair(FSIT_OP_FMUL_SD_PS, FSIT_OP_FMUL_SD_PS, 4'h0, 6'h02, 6'h05);
    pair(FSIT_OP_FMUL_PD, FSIT_OP_FMUL_SD_PS, 4'h0, 6'h09, 6'h09);
    pair(FSIT_OP_IMUL32, FSIT_OP_IMUL32, 4'h0, 6'h01, 6'h05);
    pair(FSIT_OP_IMUL16, FSIT_OP_INT, 4'h1, 6'h06, 6'h06);
  endtask
  task automatic t_div;
    nxt.divSize = 2'h0;
    pair(FSIT_OP_DIV, FSIT_OP_DIV, 4'h0, 6'h0d, 6'h0c);
    nxt.divSize = 2'h1;
    pair(FSIT_OP_DIV, FSIT_OP_DIV, 4'h0, 6'h1d, 6'h1c);
    nxt.divSig = 4'h3;
    pair(FSIT_OP_DIV, FSIT_OP_DIV, 4'h0, 6'h20, 6'h1f);
    nxt.divSig = 4'h0;
  endtask
  task automatic t_memory;
    int c;
    pair(FSIT_OP_LOAD_SPLIT, FSIT_OP_INT, 4'h1, 6'h0f, 6'h0f);
    @(negedge clk);
    memReissue = 1'b1;
    @(posedge clk);
    #1;
    fork
      go(FSIT_OP_INT, 4'h3, 4'h0, c);
      begin
        repeat (6) @(negedge clk);
        memReissue = 1'b0;
      end
    join
    cmp(c, 6'h06);
  endtask
  initial begin
    nxt = '0;
    nxt.valid = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    t_adder();
    t_mul();
    t_div();
    t_memory();
    test_done();
  end
endmodule
`default_nettype wire
